// file: pkg/ibllw_pkg.sv
package ibllw_pkg;
   // ----------------------------------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] IBLLW_OFS_CTRL = 8'h00;
   localparam logic [7:0] IBLLW_OFS_LAYOUT = 8'h04;
   localparam logic [7:0] IBLLW_OFS_LINE_BYTES = 8'h08;
   localparam logic [7:0] IBLLW_OFS_LINE_STRIDE = 8'h0C;
   localparam logic [7:0] IBLLW_OFS_GROUP_LINES = 8'h10;
   localparam logic [7:0] IBLLW_OFS_GROUP_STRIDE = 8'h14;
   localparam logic [7:0] IBLLW_OFS_BASE = 8'h18;
   localparam logic [7:0] IBLLW_OFS_STATUS = 8'h1C;
   // ----------------------------------------------------------------
   // Control and status fields
   // ----------------------------------------------------------------
   localparam int IBLLW_CTRL_MIRROR = 0;
   localparam int IBLLW_CTRL_FFC = 1;
   localparam int IBLLW_CTRL_CFA = 2;
   localparam int IBLLW_CTRL_UNPACK_MSB = 3;
   localparam int IBLLW_CTRL_ALIGN_LO = 4;
   localparam int IBLLW_CTRL_WIDE = 6;
   localparam int IBLLW_STAT_BUSY = 8;
   localparam logic [6:0] IBLLW_CTRL_RST = 7'h00;
   localparam logic [3:0] IBLLW_LAYOUT_RST = 4'h1;
   // ----------------------------------------------------------------
   // Geometry and alignment
   // ----------------------------------------------------------------
   localparam int IBLLW_LW = 24;
   localparam int IBLLW_GW = 16;
   localparam logic [5:0] IBLLW_ALIGN_PLAIN = 6'h04;
   localparam logic [5:0] IBLLW_ALIGN_FFC_LO = 6'h10;
   localparam logic [5:0] IBLLW_ALIGN_FFC_HI = 6'h20;
   localparam logic [3:0] IBLLW_BPP_MAX = 4'h8;

   typedef struct packed {
      logic [63:0] data;
      logic sof;
   } ibllw_pix_t;

   typedef struct packed {
      logic [31:0] addr;
      logic [7:0] data;
   } ibllw_wr_t;
endpackage

// file: rtl/ibllw_writer.sv
//
// Contract
// - The width step is the stride alignment over the factor it shares with bytes per pixel, at least one pixel.
// - Alignment is 4, 8, 16 or 32 bytes on plain paths, 16 or 32 when flat-field or colour decoding is on.
// - A stride above the line byte count appends stride minus count padding bytes per line.
// - A stride of zero writes lines back to back.
// - A group is adjacent lines; a group height of one makes each line its own group.
// - A group stride above the height skips stride minus height lines; zero disables it.
// - Mirroring writes the pixels of each line in reverse order.
// - Mirroring reverses pixel bytes only; line padding stays at the end.
// - Mirroring reverses whole pixels and keeps the component order inside each.
// - Mirroring is off after reset and acts only when its control is set.
// - While mirroring, unpacking is forced to the least significant bits.
// - Pixels go to ascending addresses from the buffer base unless mirrored, lines in order.
// - Multi-byte components are stored low byte first.
`timescale 1ns/10ps
`default_nettype none
module ibllw_writer (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic pix_valid,
   input wire ibllw_pkg::ibllw_pix_t pix_in,
   output logic pix_ready,
   output logic mem_valid,
   output ibllw_pkg::ibllw_wr_t mem_req,
   input wire logic mem_ready,
   output logic unpack_msb
);
   import ibllw_pkg::*;

   typedef enum logic [1:0] {ST_IDLE, ST_EMIT, ST_SKIP} ibllw_state_t;

   logic [6:0] ctrl_q;
   logic [3:0] bpp_q;
   logic [IBLLW_LW-1:0] lbc_q;
   logic [IBLLW_LW-1:0] stride_q;
   logic [IBLLW_GW-1:0] glines_q;
   logic [IBLLW_GW-1:0] gstride_q;
   logic [31:0] base_q;
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;
   ibllw_state_t state_q;
   logic [31:0] line_start_q;
   logic [IBLLW_LW-1:0] off_q;
   logic [IBLLW_GW-1:0] grp_q;
   logic [IBLLW_GW-1:0] skip_q;
   logic [63:0] pix_q;
   logic [2:0] bidx_q;
   logic pix_ready_q;
   logic mem_valid_q;
   ibllw_wr_t mem_req_q;
   logic unpack_q;

   logic mirror;
   logic [5:0] align;
   logic [5:0] step;
   logic [IBLLW_LW-1:0] line_step;
   logic [IBLLW_GW-1:0] height_eff;
   logic acc;
   logic take;
   logic [31:0] ls;
   logic [IBLLW_LW-1:0] off_cur;
   logic [IBLLW_LW-1:0] off_nxt;
   logic [31:0] pix_addr;
   logic mapped;
   logic [31:0] rd_mux;

   // ----------------------------------------------------------------
   // Derived geometry
   // ----------------------------------------------------------------
   assign mirror = ctrl_q[IBLLW_CTRL_MIRROR];
   assign take = pix_valid && pix_ready_q;

   always_comb begin
      align = IBLLW_ALIGN_PLAIN;
      if (ctrl_q[IBLLW_CTRL_FFC] || ctrl_q[IBLLW_CTRL_CFA]) begin
         align = ctrl_q[IBLLW_CTRL_WIDE] ? IBLLW_ALIGN_FFC_HI : IBLLW_ALIGN_FFC_LO;
      end else begin
         align = IBLLW_ALIGN_PLAIN << ctrl_q[IBLLW_CTRL_ALIGN_LO +: 2];
      end
   end

   // Width step; three-byte pixels share no factor with the alignment, six-byte pixels only a factor of two
   always_comb begin
      case (bpp_q)
         4'h1: step = align;
         4'h2: step = align >> 1;
         4'h3: step = align;
         4'h4: step = align >> 2;
         4'h6: step = align >> 1;
         4'h8: step = align >> 3;
         default: step = align;
      endcase
      if (step == 6'h00) begin
         step = 6'h01;
      end
   end

   // A stride of zero or below the line length leaves no gap
   assign line_step = (stride_q > lbc_q) ? stride_q : lbc_q;
   assign height_eff = (glines_q == '0) ? {{(IBLLW_GW-1){1'b0}}, 1'b1} : glines_q;

   assign ls = pix_in.sof ? base_q : line_start_q;
   assign off_cur = pix_in.sof ? '0 : off_q;
   assign off_nxt = off_cur + IBLLW_LW'(bpp_q);
   assign pix_addr = mirror ? ls + 32'(lbc_q) - 32'(off_nxt) : ls + 32'(off_cur);

   // ----------------------------------------------------------------
   // APB register file
   // ----------------------------------------------------------------
   assign acc = psel && penable && !pready_q;

   always_comb begin
      mapped = 1'b1;
      rd_mux = 32'h0000_0000;
      case (paddr)
         IBLLW_OFS_CTRL: rd_mux = {25'h000_0000, ctrl_q};
         IBLLW_OFS_LAYOUT: rd_mux = {28'h000_0000, bpp_q};
         IBLLW_OFS_LINE_BYTES: rd_mux = {8'h00, lbc_q};
         IBLLW_OFS_LINE_STRIDE: rd_mux = {8'h00, stride_q};
         IBLLW_OFS_GROUP_LINES: rd_mux = {16'h0000, glines_q};
         IBLLW_OFS_GROUP_STRIDE: rd_mux = {16'h0000, gstride_q};
         IBLLW_OFS_BASE: rd_mux = base_q;
         IBLLW_OFS_STATUS: rd_mux = {23'h00_0000, state_q != ST_IDLE, 2'h0, step};
         default: mapped = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= IBLLW_CTRL_RST;
         bpp_q <= IBLLW_LAYOUT_RST;
         lbc_q <= '0;
         stride_q <= '0;
         glines_q <= '0;
         gstride_q <= '0;
         base_q <= 32'h0000_0000;
      end else if (acc && pwrite && mapped) begin
         case (paddr)
            IBLLW_OFS_CTRL: ctrl_q <= pwdata[6:0];
            IBLLW_OFS_LAYOUT: bpp_q <= pwdata[3:0];
            IBLLW_OFS_LINE_BYTES: lbc_q <= pwdata[IBLLW_LW-1:0];
            IBLLW_OFS_LINE_STRIDE: stride_q <= pwdata[IBLLW_LW-1:0];
            IBLLW_OFS_GROUP_LINES: glines_q <= pwdata[IBLLW_GW-1:0];
            IBLLW_OFS_GROUP_STRIDE: gstride_q <= pwdata[IBLLW_GW-1:0];
            IBLLW_OFS_BASE: base_q <= pwdata;
            default: ;
         endcase
      end
   end

   // One wait state: answer on the second access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end else begin
         pready_q <= acc;
         pslverr_q <= acc && !mapped;
         prdata_q <= (acc && !pwrite) ? rd_mux : 32'h0000_0000;
      end
   end

   // Unpacking forced to lsb while mirroring
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         unpack_q <= 1'b0;
      end else begin
         unpack_q <= ctrl_q[IBLLW_CTRL_UNPACK_MSB] && !mirror;
      end
   end

   // ----------------------------------------------------------------
   // Line layout engine
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= ST_IDLE;
         line_start_q <= 32'h0000_0000;
         off_q <= '0;
         grp_q <= '0;
         skip_q <= '0;
         pix_q <= 64'h0000_0000_0000_0000;
         bidx_q <= 3'h0;
         pix_ready_q <= 1'b0;
         mem_valid_q <= 1'b0;
         mem_req_q <= '0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               pix_ready_q <= 1'b1;
               if (take) begin
                  pix_ready_q <= 1'b0;
                  line_start_q <= ls;
                  if (pix_in.sof) begin
                     grp_q <= '0;
                  end
                  off_q <= off_nxt;
                  pix_q <= pix_in.data;
                  bidx_q <= 3'h0;
                  mem_valid_q <= 1'b1;
                  mem_req_q.addr <= pix_addr;
                  mem_req_q.data <= pix_in.data[7:0];
                  state_q <= ST_EMIT;
               end
            end
            ST_EMIT: begin
               if (mem_ready) begin
                  if ({1'b0, bidx_q} == bpp_q - 4'h1) begin
                     mem_valid_q <= 1'b0;
                     pix_ready_q <= 1'b1;
                     state_q <= ST_IDLE;
                     if (off_q >= lbc_q) begin
                        off_q <= '0;
                        line_start_q <= line_start_q + 32'(line_step);
                        if (grp_q + 1'b1 >= height_eff) begin
                           grp_q <= '0;
                           if (gstride_q > height_eff) begin
                              skip_q <= gstride_q - height_eff;
                              pix_ready_q <= 1'b0;
                              state_q <= ST_SKIP;
                           end
                        end else begin
                           grp_q <= grp_q + 1'b1;
                        end
                     end
                  end else begin
                     bidx_q <= bidx_q + 3'h1;
                     mem_req_q.addr <= mem_req_q.addr + 32'h0000_0001;
                     mem_req_q.data <= pix_q[{bidx_q + 3'h1, 3'h0} +: 8];
                  end
               end
            end
            ST_SKIP: begin
               line_start_q <= line_start_q + 32'(line_step);
               skip_q <= skip_q - 1'b1;
               if (skip_q == {{(IBLLW_GW-1){1'b0}}, 1'b1}) begin
                  pix_ready_q <= 1'b1;
                  state_q <= ST_IDLE;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign pix_ready = pix_ready_q;
   assign mem_valid = mem_valid_q;
   assign mem_req = mem_req_q;
   assign unpack_msb = unpack_q;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   property p_step_min;
      @(posedge pclk) disable iff (!presetn) step != 6'h00;
   endproperty
   a_step_min: assert property (p_step_min) else $error("width step zero");

   property p_align;
      @(posedge pclk) disable iff (!presetn)
         (ctrl_q[IBLLW_CTRL_FFC] || ctrl_q[IBLLW_CTRL_CFA]) |-> align >= IBLLW_ALIGN_FFC_LO;
   endproperty
   a_align: assert property (p_align) else $error("alignment too small");

   property p_line_adv;
      @(posedge pclk) disable iff (!presetn)
         (state_q == ST_EMIT && mem_ready && {1'b0, bidx_q} == bpp_q - 4'h1 && off_q >= lbc_q)
         |=> line_start_q == $past(line_start_q) + 32'($past(line_step));
   endproperty
   a_line_adv: assert property (p_line_adv) else $error("line advance wrong");

   property p_no_gap;
      @(posedge pclk) disable iff (!presetn) (stride_q == '0) |-> line_step == lbc_q;
   endproperty
   a_no_gap: assert property (p_no_gap) else $error("zero stride not packed");

   property p_skip_exit;
      @(posedge pclk) disable iff (!presetn)
         (state_q == ST_SKIP && skip_q == {{(IBLLW_GW-1){1'b0}}, 1'b1}) |=> state_q == ST_IDLE;
   endproperty
   a_skip_exit: assert property (p_skip_exit) else $error("skip count wrong");

   property p_mirror_addr;
      @(posedge pclk) disable iff (!presetn)
         (take && mirror) |=> mem_req_q.addr == $past(ls) + 32'($past(lbc_q)) - 32'($past(off_nxt));
   endproperty
   a_mirror_addr: assert property (p_mirror_addr) else $error("mirror address wrong");

   property p_fwd_addr;
      @(posedge pclk) disable iff (!presetn)
         (take && !mirror) |=> mem_req_q.addr == $past(ls) + 32'($past(off_cur));
   endproperty
   a_fwd_addr: assert property (p_fwd_addr) else $error("forward address wrong");

   property p_unpack;
      @(posedge pclk) disable iff (!presetn) $past(mirror) |-> !unpack_q;
   endproperty
   a_unpack: assert property (p_unpack) else $error("unpack not forced");

   property p_le_byte;
      @(posedge pclk) disable iff (!presetn)
         (state_q == ST_EMIT && mem_ready && mem_valid_q && {1'b0, bidx_q} != bpp_q - 4'h1)
         |=> mem_req_q.addr == $past(mem_req_q.addr) + 32'h0000_0001;
   endproperty
   a_le_byte: assert property (p_le_byte) else $error("byte order wrong");

   property p_skip_quiet;
      @(posedge pclk) disable iff (!presetn) state_q == ST_SKIP |-> !mem_valid_q;
   endproperty
   a_skip_quiet: assert property (p_skip_quiet) else $error("padding written");

   // Every emitted byte falls inside the pixel bytes of its line, never in the padding
   property p_pad_untouched;
      @(posedge pclk) disable iff (!presetn)
         (state_q == ST_EMIT && mem_valid_q) |-> (mem_req_q.addr - line_start_q) < 32'(lbc_q);
   endproperty
   a_pad_untouched: assert property (p_pad_untouched) else $error("byte written into padding");

   // A stalled byte request keeps its address and data until the sink takes it
   property p_req_hold;
      @(posedge pclk) disable iff (!presetn)
         (mem_valid_q && !mem_ready) |=> (mem_valid_q && $stable(mem_req_q));
   endproperty
   a_req_hold: assert property (p_req_hold) else $error("byte request dropped");

   // No pixel is accepted while padding lines are being skipped
   property p_ready_idle;
      @(posedge pclk) disable iff (!presetn) pix_ready_q |-> state_q == ST_IDLE;
   endproperty
   a_ready_idle: assert property (p_ready_idle) else $error("pixel accepted while busy");

   // The low byte of each pixel goes out first
   property p_low_first;
      @(posedge pclk) disable iff (!presetn)
         take |=> (mem_valid_q && mem_req_q.data == $past(pix_in.data[7:0]));
   endproperty
   a_low_first: assert property (p_low_first) else $error("first byte not low byte");
endmodule // ibllw_writer
`default_nettype wire

// file: test/ibllw_mem_sink.sv
`timescale 1ns/10ps
`default_nettype none
module ibllw_mem_sink (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic slow,
   input wire logic mem_valid,
   input wire ibllw_pkg::ibllw_wr_t mem_req,
   output logic mem_ready
);
   import ibllw_pkg::*;
   logic [7:0] mem [0:255];
   // Stalls every other cycle while slow is set
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mem_ready <= 1'b0;
      end else begin
         mem_ready <= slow ? ~mem_ready : 1'b1;
      end
   end
   always @(posedge pclk) begin
      if (mem_valid && mem_ready) begin
         mem[mem_req.addr[7:0]] <= mem_req.data;
      end
   end
endmodule // ibllw_mem_sink
`default_nettype wire

// file: test/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import ibllw_pkg::*;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic pix_valid = 1'b0, slow = 1'b0, mem_valid, mem_ready, pix_ready, pready, pslverr, unpack_msb;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic err;
   ibllw_pix_t pix_in = '0;
   ibllw_wr_t mem_req;
   logic [7:0] expb [0:255];
   int n_mismatch = 0, num_checks = 0, cyc = 0;
   int c_bpp, c_lb, c_ls, c_gl, c_gs, c_mir;
   int bl [6] = '{1, 2, 3, 4, 6, 8};
   ibllw_writer ibllw_writer_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pix_valid(pix_valid), .pix_in(pix_in), .pix_ready(pix_ready), .mem_valid(mem_valid),
      .mem_req(mem_req), .mem_ready(mem_ready), .unpack_msb(unpack_msb));
   ibllw_mem_sink ibllw_mem_sink_inst (.pclk(pclk), .presetn(presetn), .slow(slow),
      .mem_valid(mem_valid), .mem_req(mem_req), .mem_ready(mem_ready));
   always #10 pclk = ~pclk;
   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task final_report();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         final_report();
      end
   end
   task check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task cfg(input int ct, input int bp, input int lb, input int ls, input int gl, input int gs);
      c_bpp = bp;
      c_lb = lb;
      c_ls = ls;
      c_gl = gl;
      c_gs = gs;
      c_mir = ct & 1;
      apb(1'b1, IBLLW_OFS_CTRL, ct);
      apb(1'b1, IBLLW_OFS_LAYOUT, bp);
      apb(1'b1, IBLLW_OFS_LINE_BYTES, lb);
      apb(1'b1, IBLLW_OFS_LINE_STRIDE, ls);
      apb(1'b1, IBLLW_OFS_GROUP_LINES, gl);
      apb(1'b1, IBLLW_OFS_GROUP_STRIDE, gs);
      apb(1'b1, IBLLW_OFS_BASE, 32'h10);
   endtask
   // Sends nl lines of one frame and compares the whole buffer with the reference
   task run_frame(input int nl, input logic sl);
      int pitch, gh, pad, st, ad;
      logic [63:0] d;
      slow <= sl;
      for (int i = 0; i < 256; i++) begin
         ibllw_mem_sink_inst.mem[i] = 8'hEE;
         expb[i] = 8'hEE;
      end
      pitch = (c_ls > c_lb) ? c_ls : c_lb;
      gh = (c_gl == 0) ? 1 : c_gl;
      pad = (c_gs > gh) ? c_gs - gh : 0;
      for (int l = 0; l < nl; l++) begin
         st = 16 + (l + (l / gh) * pad) * pitch;
         for (int p = 0; p < c_lb / c_bpp; p++) begin
            d = '0;
            for (int k = 0; k < c_bpp; k++) begin
               d[8*k +: 8] = 8'(8'h40 + l * 16 + p * c_bpp + k);
               ad = st + (c_mir ? c_lb - (p + 1) * c_bpp : p * c_bpp) + k;
               expb[ad] = d[8*k +: 8];
            end
            @(posedge pclk);
            pix_valid <= 1'b1;
            pix_in.data <= d;
            pix_in.sof <= (l == 0 && p == 0);
            do begin
               @(posedge pclk);
            end while (pix_ready !== 1'b1);
            pix_valid <= 1'b0;
         end
      end
      do begin
         @(posedge pclk);
      end while (pix_ready !== 1'b1 || mem_valid !== 1'b0);
      for (int i = 0; i < 256; i++) begin
         check(ibllw_mem_sink_inst.mem[i], expb[i]);
      end
   endtask
   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial begin
      int a, ex;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, IBLLW_OFS_CTRL, 0);
      check(rd, 32'h0);
      check(unpack_msb, 1'b0);
      apb(1'b0, IBLLW_OFS_LAYOUT, 0);
      check(rd, 32'h1);
      apb(1'b0, 8'h20, 0);
      check(err, 1'b1);
      check(rd, 32'h0);
      for (int i = 0; i < 6; i++) begin
         for (int n = 0; n < 4; n++) begin
            apb(1'b1, IBLLW_OFS_LAYOUT, bl[i]);
            apb(1'b1, IBLLW_OFS_CTRL, n << 4);
            apb(1'b0, IBLLW_OFS_STATUS, 0);
            a = 4 << n;
            ex = (bl[i] == 3) ? a : (bl[i] == 6) ? a / 2 : a / bl[i];
            ex = (ex < 1) ? 1 : ex;
            check(rd[5:0], ex);
         end
      end
      apb(1'b1, IBLLW_OFS_LAYOUT, 1);
      apb(1'b1, IBLLW_OFS_CTRL, 32'h02);
      apb(1'b0, IBLLW_OFS_STATUS, 0);
      check(rd[5:0], 16);
      apb(1'b1, IBLLW_OFS_CTRL, 32'h04);
      apb(1'b0, IBLLW_OFS_STATUS, 0);
      check(rd[5:0], 16);
      apb(1'b1, IBLLW_OFS_CTRL, 32'h46);
      apb(1'b0, IBLLW_OFS_STATUS, 0);
      check(rd[5:0], 32);
      // Widths below are whole multiples of the step in force
      cfg(32'h08, 2, 8, 12, 2, 3);
      run_frame(3, 1'b0);
      check(unpack_msb, 1'b1);
      cfg(32'h09, 3, 12, 16, 1, 0);
      @(posedge pclk);
      check(unpack_msb, 1'b0);
      run_frame(2, 1'b1);
      cfg(32'h01, 4, 8, 0, 1, 2);
      run_frame(3, 1'b1);
      cfg(32'h00, 1, 4, 0, 0, 0);
      run_frame(3, 1'b0);
      final_report();
   end
endmodule // testbench
`default_nettype wire
